/* File: rtl/pwr_wake_pkg.sv */
/*
 * Package for the board power-state and wake controller: register offsets,
 * field positions, reset values, timing constants, state encoding and
 * carrier structs.
 * Assumes a single 100 MHz standby clock domain.
 */
package pwr_wake_pkg;

    // Register word offsets
    localparam logic [3:0] ctrl_off = 4'h0;
    localparam logic [3:0] state_off = 4'h1;
    localparam logic [3:0] thresh_off = 4'h2;
    localparam logic [3:0] irq_stat_off = 4'h3;
    localparam logic [3:0] irq_mask_off = 4'h4;
    localparam logic [3:0] hwmon_off = 4'h5;
    localparam logic [3:0] limit_off = 4'h6;
    localparam logic [3:0] fan_off = 4'h7;

    // Control field positions
    localparam int ctrl_s5_lan_pos = 0;
    localparam int ctrl_s5_pme_pos = 1;
    localparam int ctrl_req_pos = 4;

    // Interrupt status positions
    localparam int ev_wake_pos = 0;
    localparam int ev_short_pos = 1;
    localparam int ev_long_pos = 2;
    localparam int ev_intr_pos = 3;
    localparam int ev_rail_pos = 4;
    localparam int ev_cold_pos = 5;

    // Reset values
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    localparam logic [31:0] thresh_reset = 32'h17D7_8400;
    localparam logic [5:0] mask_reset = 6'h00;

    // Timing
    localparam int clk_mhz = 100;
    localparam int debounce_us = 20;
    localparam int debounce_cycles = debounce_us * clk_mhz;
    localparam int hold_s = 4;

    // Wake-source indices
    localparam int wk_lan = 0;
    localparam int wk_modem = 1;
    localparam int wk_pme = 2;
    localparam int wk_switch = 3;
    localparam int wk_ps2 = 4;
    localparam int wk_rtc = 5;
    localparam int wk_usb = 6;
    localparam int wk_pcie = 7;
    localparam int num_wake = 8;
    localparam int num_rails = 5;
    localparam int num_fans = 3;

    // Power states, Gray coded along S0-S1-S3-S4-S5
    typedef enum logic [2:0] {
        st_s0 = 3'h0,
        st_s1 = 3'h1,
        st_s3 = 3'h3,
        st_s4 = 3'h2,
        st_s5 = 3'h6
    } pstate_type;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } window_type;

    typedef struct packed {
        logic [7:0] temp;
        logic [7:0] on_temp;
    } fan_in_type;

endpackage

/* File: rtl/pwr_wake_ctrl.sv */
/*
 * Board power-state and wake controller with an Avalon-MM register slave.
 * Assumes pins from outside (switch, wake sources, intrusion) are
 * asynchronous, rail and temperature codes come from same-clock converters,
 * and the operating system writes sleep requests through the ctrl register.
 */
// Notes on behaviour
// - From soft-off a short switch press powers the system on.
// - From working a short switch press puts the system to sleep.
// - From working a long press forces soft-off whatever software does.
// - From sleep a short press wakes and a long press powers off.
// - Modem, PS/2 and USB wake only from S1 or S3.
// - LAN, PME, switch, RTC and PCIe wake from S1, S3, S4 and S5.
// - LAN and PME wake from S5 is off after reset until enabled.
// - A closed intrusion switch is recorded as cover removed.
// - Leaving S5 is flagged as a cold boot.
// - Each of five rails is checked against upper and lower limits.
// - Each of three fans is switched by its own temperature input.
// - Fans run in S0 and S1 only.
`timescale 1ns/1ns
module pwr_wake_ctrl (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Pins
    input wire logic pwr_switch_n,
    input wire logic [7:0] wake_req,
    input wire logic intrusion_closed,
    // Monitor inputs
    input wire logic [39:0] rail_code,
    input wire logic [47:0] fan_temp,
    // Outputs
    output logic [2:0] power_state,
    output logic cold_boot,
    output logic [2:0] fan_on,
    output logic irq
);

    pwr_wake_pkg::pstate_type state_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] thresh_reg;
    logic [5:0] stat_reg;
    logic [5:0] mask_reg;
    logic [4:0] rail_bad_reg;
    logic intr_reg;
    pwr_wake_pkg::window_type limit_reg [5];
    logic [7:0] fan_on_temp [3];
    logic [1:0] ack_reg;
    logic [8:0] sw_s1, sw_s2;
    logic [19:0] db_cnt_reg;
    logic sw_db_reg;
    logic [31:0] hold_cnt_reg;
    logic long_done_reg;
    logic [5:0] ev;
    logic [7:0] wake_ok;
    logic short_p, long_p, any_wake;
    logic sleep_req;

    // Honours a wake source in a given state
    function automatic logic wake_allowed(input int src,
        input pwr_wake_pkg::pstate_type st, input logic [31:0] ctl);
        logic ok;
        ok = 1'b0;
        case (st)
            pwr_wake_pkg::st_s1, pwr_wake_pkg::st_s3: ok = 1'b1;
            pwr_wake_pkg::st_s4: ok = (src == pwr_wake_pkg::wk_lan) ||
                (src == pwr_wake_pkg::wk_pme) ||
                (src == pwr_wake_pkg::wk_switch) ||
                (src == pwr_wake_pkg::wk_rtc) ||
                (src == pwr_wake_pkg::wk_pcie);
            pwr_wake_pkg::st_s5:
            begin
                if (src == pwr_wake_pkg::wk_lan)
                    ok = ctl[pwr_wake_pkg::ctrl_s5_lan_pos];
                else if (src == pwr_wake_pkg::wk_pme)
                    ok = ctl[pwr_wake_pkg::ctrl_s5_pme_pos];
                else
                    ok = (src == pwr_wake_pkg::wk_switch) ||
                        (src == pwr_wake_pkg::wk_rtc) ||
                        (src == pwr_wake_pkg::wk_pcie);
            end
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Pin synchronisers
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sw_s1 <= 9'h000;
            sw_s2 <= 9'h000;
        end
        else if (clk_en)
        begin
            sw_s1 <= {intrusion_closed, wake_req} ^ 9'h000;
            sw_s2 <= sw_s1;
        end
    end

    logic sw_raw_n;
    logic sw_pin_s1, sw_pin_s2;
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sw_pin_s1 <= 1'b1;
            sw_pin_s2 <= 1'b1;
        end
        else if (clk_en)
        begin
            sw_pin_s1 <= pwr_switch_n;
            sw_pin_s2 <= sw_pin_s1;
        end
    end
    assign sw_raw_n = sw_pin_s2;

    // Debounce and press timing
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            db_cnt_reg <= 20'h00000;
            sw_db_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!sw_raw_n == sw_db_reg)
                db_cnt_reg <= 20'h00000;
            else if (db_cnt_reg ==
                20'(pwr_wake_pkg::debounce_cycles - 1))
            begin
                sw_db_reg <= !sw_raw_n;
                db_cnt_reg <= 20'h00000;
            end
            else
                db_cnt_reg <= db_cnt_reg + 20'h00001;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hold_cnt_reg <= 32'h0000_0000;
            long_done_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!sw_db_reg)
            begin
                hold_cnt_reg <= 32'h0000_0000;
                long_done_reg <= 1'b0;
            end
            else
            begin
                if (hold_cnt_reg != 32'hFFFF_FFFF)
                    hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
                if (long_p)
                    long_done_reg <= 1'b1;
            end
        end
    end

    logic sw_db_d;
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            sw_db_d <= 1'b0;
        else if (clk_en)
            sw_db_d <= sw_db_reg;
    end

    assign long_p = sw_db_reg && !long_done_reg &&
        (hold_cnt_reg >= thresh_reg);
    assign short_p = sw_db_d && !sw_db_reg && !long_done_reg;

    always_comb
    begin
        for (int i = 0; i < pwr_wake_pkg::num_wake; i++)
            wake_ok[i] = sw_s2[i] && wake_allowed(i, state_reg, ctrl_reg);
    end
    assign any_wake = |wake_ok;
    assign sleep_req = ctrl_reg[pwr_wake_pkg::ctrl_req_pos +: 3] != 3'h0;

    // Power-state machine
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            state_reg <= pwr_wake_pkg::st_s5;
        else if (clk_en)
        begin
            case (state_reg)
                pwr_wake_pkg::st_s0:
                begin
                    if (long_p)
                        state_reg <= pwr_wake_pkg::st_s5;
                    else if (short_p)
                        state_reg <= pwr_wake_pkg::st_s1;
                    else if (sleep_req)
                        state_reg <= pwr_wake_pkg::pstate_type'(
                            ctrl_reg[pwr_wake_pkg::ctrl_req_pos +: 3]);
                end
                pwr_wake_pkg::st_s1, pwr_wake_pkg::st_s3,
                pwr_wake_pkg::st_s4:
                begin
                    if (long_p)
                        state_reg <= pwr_wake_pkg::st_s5;
                    else if (short_p || any_wake)
                        state_reg <= pwr_wake_pkg::st_s0;
                end
                pwr_wake_pkg::st_s5:
                    if (short_p || any_wake)
                        state_reg <= pwr_wake_pkg::st_s0;
                default: state_reg <= pwr_wake_pkg::st_s5;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            cold_boot <= 1'b0;
        else if (clk_en)
        begin
            if (state_reg == pwr_wake_pkg::st_s5 && (short_p || any_wake))
                cold_boot <= 1'b1;
            else if (state_reg != pwr_wake_pkg::st_s0)
                cold_boot <= 1'b0;
        end
    end

    // Hardware monitor
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rail_bad_reg <= 5'h00;
            intr_reg <= 1'b0;
            fan_on <= 3'h0;
        end
        else if (clk_en)
        begin
            for (int i = 0; i < pwr_wake_pkg::num_rails; i++)
                rail_bad_reg[i] <= rail_code[i*8 +: 8] > limit_reg[i].hi ||
                    rail_code[i*8 +: 8] < limit_reg[i].lo;
            intr_reg <= sw_s2[8];
            for (int f = 0; f < pwr_wake_pkg::num_fans; f++)
                fan_on[f] <= (fan_temp[f*16 +: 8] >= fan_on_temp[f]) &&
                    (state_reg == pwr_wake_pkg::st_s0 ||
                    state_reg == pwr_wake_pkg::st_s1);
        end
    end

    // Events
    always_comb
    begin
        ev = 6'h00;
        ev[pwr_wake_pkg::ev_wake_pos] = any_wake;
        ev[pwr_wake_pkg::ev_short_pos] = short_p;
        ev[pwr_wake_pkg::ev_long_pos] = long_p;
        ev[pwr_wake_pkg::ev_intr_pos] = intr_reg;
        ev[pwr_wake_pkg::ev_rail_pos] = |rail_bad_reg;
        ev[pwr_wake_pkg::ev_cold_pos] = state_reg == pwr_wake_pkg::st_s5 &&
            (short_p || any_wake);
    end

    // Register slave
    logic wr_hit, rd_hit;
    // Writes land at the edge where the master sees waitrequest low
    assign wr_hit = avs_write && !avs_waitrequest;
    assign rd_hit = avs_read && ack_reg == 2'h0;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_reg <= pwr_wake_pkg::ctrl_reset;
            thresh_reg <= pwr_wake_pkg::thresh_reset;
            mask_reg <= pwr_wake_pkg::mask_reset;
            for (int i = 0; i < 5; i++)
                limit_reg[i] <= 16'hFF00;
            for (int i = 0; i < 3; i++)
                fan_on_temp[i] <= 8'h28;
        end
        else if (clk_en)
        begin
            if (state_reg == pwr_wake_pkg::st_s0 && sleep_req)
                ctrl_reg[pwr_wake_pkg::ctrl_req_pos +: 3] <= 3'h0;
            if (wr_hit)
            begin
                case (avs_address)
                    pwr_wake_pkg::ctrl_off: ctrl_reg <= avs_writedata;
                    pwr_wake_pkg::thresh_off: thresh_reg <= avs_writedata;
                    pwr_wake_pkg::irq_mask_off: mask_reg <= avs_writedata[5:0];
                    pwr_wake_pkg::limit_off:
                        limit_reg[avs_writedata[18:16]] <= avs_writedata[15:0];
                    pwr_wake_pkg::fan_off:
                        fan_on_temp[avs_writedata[9:8]] <= avs_writedata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // Sticky status: set wins over write-one clear
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            stat_reg <= 6'h00;
        else if (clk_en)
        begin
            if (wr_hit && avs_address == pwr_wake_pkg::irq_stat_off)
                stat_reg <= (stat_reg & ~avs_writedata[5:0]) | ev;
            else
                stat_reg <= stat_reg | ev;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_reg <= 2'h0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            avs_waitrequest <= 1'b1;
            if (ack_reg != 2'h0)
                ack_reg <= 2'h0;
            else if (avs_read || avs_write)
            begin
                ack_reg <= 2'h1;
                avs_waitrequest <= 1'b0;
            end
            if (rd_hit)
            begin
                case (avs_address)
                    pwr_wake_pkg::ctrl_off: avs_readdata <= ctrl_reg;
                    pwr_wake_pkg::state_off:
                        avs_readdata <= {28'h0, cold_boot, state_reg};
                    pwr_wake_pkg::thresh_off: avs_readdata <= thresh_reg;
                    pwr_wake_pkg::irq_stat_off:
                        avs_readdata <= {26'h0, stat_reg};
                    pwr_wake_pkg::irq_mask_off:
                        avs_readdata <= {26'h0, mask_reg};
                    pwr_wake_pkg::hwmon_off:
                        avs_readdata <= {23'h0, fan_on, intr_reg,
                            rail_bad_reg};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq <= 1'b0;
            power_state <= 3'h6;
        end
        else if (clk_en)
        begin
            irq <= |(stat_reg & ~mask_reg);
            power_state <= state_reg;
        end
    end

endmodule

/* File: tb/pwr_wake_monitor.sv */
/* Assertion checker for the power and wake controller.
   Bound to pwr_wake_ctrl; sees only its ports. */
`timescale 1ns/1ns
module pwr_wake_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Register writes
    input wire logic [3:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    // Pins and state
    input wire logic pwr_switch_n,
    input wire logic [7:0] wake_req,
    input wire logic [2:0] power_state,
    input wire logic cold_boot,
    input wire logic [2:0] fan_on
);
    logic en_seen_reg;
    logic [20:0] rel_cnt;
    logic sw_quiet;

    // Cycles since the switch was last pressed; a release acts only
    // after the debounce span
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            rel_cnt <= 21'h1FFFFF;
        else if (!pwr_switch_n)
            rel_cnt <= 21'h000000;
        else if (rel_cnt != 21'h1FFFFF)
            rel_cnt <= rel_cnt + 21'h000001;
    end
    assign sw_quiet = rel_cnt > 21'(pwr_wake_pkg::debounce_cycles + 16);

    // Notes any write that turns on soft-off wake by LAN or PME
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            en_seen_reg <= 1'b0;
        else if (avs_write && avs_address == 4'h0 &&
            avs_writedata[1:0] != 2'h0)
            en_seen_reg <= 1'b1;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    chk_deep_ignore: assert property (
        ((power_state == 3'h2 || power_state == 3'h6) && sw_quiet &&
        (wake_req & 8'hAD) == 8'h00)[*6] |=> power_state != 3'h0)
        else $error("state left S4 or S5 without a deep wake source");
    chk_shallow_wake: assert property (
        (power_state == 3'h1 && wake_req[6])[*3] |->
        ##[0:6] power_state == 3'h0)
        else $error("USB wake from S1 not honoured");
    chk_deep_wake: assert property (
        (power_state == 3'h2 && wake_req[7])[*3] |->
        ##[0:6] power_state == 3'h0)
        else $error("PCIe wake from S4 not honoured");
    chk_off_wake: assert property (
        (power_state == 3'h6 && wake_req[5])[*3] |->
        ##[0:6] power_state == 3'h0)
        else $error("RTC wake from S5 not honoured");
    chk_s5_default: assert property (
        (!en_seen_reg && power_state == 3'h6 && sw_quiet &&
        (wake_req & 8'hA8) == 8'h00)[*6] |=> power_state == 3'h6)
        else $error("S5 left by a source that is off by default");
    chk_cold_flag: assert property (
        (power_state == 3'h6 ##1 power_state == 3'h0) |-> ##[0:1] cold_boot)
        else $error("leaving S5 not flagged as cold boot");
    chk_off_exit: assert property (
        (power_state == 3'h6 ##1 power_state != 3'h6) |->
        power_state == 3'h0)
        else $error("S5 left to a state other than S0");
    chk_fans_idle: assert property (
        (power_state != 3'h0 && power_state != 3'h1)[*3] |-> fan_on == 3'h0)
        else $error("fan running outside S0 and S1");
endmodule
bind pwr_wake_ctrl pwr_wake_monitor mon (
    .clk_sys, .arst_n, .avs_address, .avs_write, .avs_writedata,
    .pwr_switch_n, .wake_req, .power_state, .cold_boot, .fan_on);

/* File: tb/wake_source_model.sv */
/* Far-side model: front-panel switch, wake sources and cover switch.
   Assumes the controller synchronises these pins itself. */
`timescale 1ns/1ns
module wake_source_model (
    // Clock
    input wire logic clk_sys,
    // Pins toward the controller
    output logic pwr_switch_n,
    output logic [7:0] wake_req,
    output logic intrusion_closed
);
    // Switch released on its pull-up, no source asking, cover on
    initial
    begin
        pwr_switch_n = 1'b1;
        wake_req = 8'h00;
        intrusion_closed = 1'b0;
    end

    task automatic set_wake(input int idx, input logic lvl);
        @(posedge clk_sys);
        wake_req[idx] <= lvl;
    endtask

    // Holds the switch down for the given number of cycles
    task automatic press(input int cycles);
        @(posedge clk_sys);
        pwr_switch_n <= 1'b0;
        repeat (cycles) @(posedge clk_sys);
        pwr_switch_n <= 1'b1;
    endtask

    task automatic set_cover(input logic closed);
        @(posedge clk_sys);
        intrusion_closed <= closed;
    endtask
endmodule

/* File: tb/board_power_state_and_wake_control_test.sv */
/* Self-checking bench for the power and wake controller.
   Assumes a debounce span of a few thousand cycles and a hold threshold
   written short, so switch presses fit within a run. */
`timescale 1ns/1ns
module board_power_state_and_wake_control_test;
    typedef struct packed {
        logic [2:0] st;
        logic [2:0] src;
        logic wakes;
    } row_type;
    // Sleep state, wake source, whether it wakes
    localparam row_type rows [16] = '{
        '{3'h1, 3'h1, 1'b1}, '{3'h1, 3'h6, 1'b1}, '{3'h3, 3'h4, 1'b1},
        '{3'h3, 3'h5, 1'b1}, '{3'h2, 3'h1, 1'b0}, '{3'h2, 3'h4, 1'b0},
        '{3'h2, 3'h6, 1'b0}, '{3'h2, 3'h0, 1'b1}, '{3'h2, 3'h2, 1'b1},
        '{3'h2, 3'h3, 1'b1}, '{3'h6, 3'h6, 1'b0}, '{3'h6, 3'h0, 1'b0},
        '{3'h6, 3'h2, 1'b0}, '{3'h6, 3'h7, 1'b1}, '{3'h6, 3'h5, 1'b1},
        '{3'h3, 3'h7, 1'b1}};
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [39:0] rail_code = 40'h40_4040_4040;
    logic [47:0] fan_temp = 48'h0050_0050_0050;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, cold_boot, irq, pwr_switch_n, intrusion_closed;
    logic [2:0] power_state, fan_on;
    logic [7:0] wake_req;
    logic [1:0] en = 2'h0;
    int err_count = 0;
    int check_count = 0;

    always #5 clk_sys = ~clk_sys;

    pwr_wake_ctrl dut (
        .clk_sys, .arst_n, .clk_en(1'b1), .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .pwr_switch_n, .wake_req, .intrusion_closed, .rail_code,
        .fan_temp, .power_state, .cold_boot, .fan_on, .irq);
    wake_source_model far (
        .clk_sys, .pwr_switch_n, .wake_req, .intrusion_closed);

    task automatic cmp(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude;
        if (err_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // One bus transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do
            @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic go(input logic [2:0] st);
        bus(1'b1, pwr_wake_pkg::ctrl_off, {25'h0, st, 2'h0, en});
        idle(20);
        cmp("state", st, power_state);
    endtask

    task automatic recover;
        far.set_wake(7, 1'b1);
        idle(20);
        cmp("state", pwr_wake_pkg::st_s0, power_state);
        far.set_wake(7, 1'b0);
        idle(5);
    endtask

    initial
    begin
        idle(10);
        arst_n <= 1'b1;
        cmp("state", pwr_wake_pkg::st_s5, power_state);
        bus(1'b0, pwr_wake_pkg::ctrl_off, 0);
        cmp("ctrl", pwr_wake_pkg::ctrl_reset, rd);
        bus(1'b0, pwr_wake_pkg::thresh_off, 0);
        cmp("thresh", pwr_wake_pkg::thresh_reset, rd);
        bus(1'b0, pwr_wake_pkg::irq_mask_off, 0);
        cmp("mask", 32'h0, rd);
        bus(1'b0, 4'hF, 0);
        cmp("unmapped", 32'h0, rd);
        far.set_wake(0, 1'b1);
        idle(20);
        cmp("state", pwr_wake_pkg::st_s5, power_state);
        far.set_wake(0, 1'b0);
        recover();
        cmp("cold", 1'b1, cold_boot);
        for (int i = 0; i < 16; i++)
        begin
            go(rows[i].st);
            far.set_wake(rows[i].src, 1'b1);
            idle(20);
            cmp("wake", rows[i].wakes ? 3'h0 : rows[i].st, power_state);
            far.set_wake(rows[i].src, 1'b0);
            idle(5);
            if (power_state !== 3'h0)
                recover();
            else
                cmp("cold", rows[i].st == 3'h6, cold_boot);
        end
        en = 2'h3;
        for (int s = 0; s < 3; s += 2)
        begin
            go(3'h6);
            far.set_wake(s, 1'b1);
            idle(20);
            cmp("s5 wake", 3'h0, power_state);
            far.set_wake(s, 1'b0);
            idle(5);
        end
        cmp("fans", 3'h7, fan_on);
        fan_temp[23:16] <= 8'h10;
        idle(5);
        cmp("fans", 3'h5, fan_on);
        bus(1'b1, pwr_wake_pkg::fan_off, 32'h0000_0060);
        idle(5);
        cmp("fans", 3'h4, fan_on);
        go(3'h1);
        cmp("fans", 3'h4, fan_on);
        recover();
        go(3'h3);
        cmp("fans", 3'h0, fan_on);
        recover();
        bus(1'b1, pwr_wake_pkg::limit_off, 32'h0004_8010);
        rail_code[39:32] <= 8'h90;
        idle(5);
        bus(1'b0, pwr_wake_pkg::hwmon_off, 0);
        cmp("rails", 5'h10, rd[4:0]);
        rail_code[39:32] <= 8'h08;
        idle(5);
        bus(1'b0, pwr_wake_pkg::hwmon_off, 0);
        cmp("rails", 5'h10, rd[4:0]);
        rail_code[39:32] <= 8'h40;
        idle(5);
        bus(1'b1, pwr_wake_pkg::irq_stat_off, 32'h3F);
        bus(1'b0, pwr_wake_pkg::irq_stat_off, 0);
        cmp("status", 32'h0, rd);
        cmp("irq", 1'b0, irq);
        far.set_cover(1'b1);
        idle(10);
        bus(1'b0, pwr_wake_pkg::hwmon_off, 0);
        cmp("cover", 1'b1, rd[5]);
        bus(1'b0, pwr_wake_pkg::irq_stat_off, 0);
        cmp("status", 32'h08, rd);
        cmp("irq", 1'b1, irq);
        bus(1'b1, pwr_wake_pkg::irq_mask_off, 32'h08);
        idle(3);
        cmp("irq", 1'b0, irq);
        far.set_cover(1'b0);
        idle(10);
        bus(1'b1, pwr_wake_pkg::irq_stat_off, 32'h08);
        bus(1'b0, pwr_wake_pkg::irq_stat_off, 0);
        cmp("status", 32'h0, rd);
        bus(1'b1, pwr_wake_pkg::thresh_off, 32'h0000_1000);
        far.press(3000);
        idle(2100);
        cmp("state", pwr_wake_pkg::st_s1, power_state);
        far.press(3000);
        idle(2100);
        cmp("state", pwr_wake_pkg::st_s0, power_state);
        far.press(7000);
        idle(2100);
        cmp("state", pwr_wake_pkg::st_s5, power_state);
        far.press(3000);
        idle(2100);
        cmp("state", pwr_wake_pkg::st_s0, power_state);
        cmp("cold", 1'b1, cold_boot);
        go(3'h3);
        far.press(7000);
        idle(2100);
        cmp("state", pwr_wake_pkg::st_s5, power_state);
        bus(1'b0, pwr_wake_pkg::irq_stat_off, 0);
        cmp("status", 32'h26, rd);
        cmp("irq", 1'b1, irq);
        arst_n <= 1'b0;
        idle(2);
        cmp("state", pwr_wake_pkg::st_s5, power_state);
        cmp("irq", 1'b0, irq);
        arst_n <= 1'b1;
        bus(1'b0, pwr_wake_pkg::thresh_off, 0);
        cmp("thresh", pwr_wake_pkg::thresh_reset, rd);
        conclude();
    end

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        err_count++;
        conclude();
    end
endmodule
